// [hw/pwm_timebase_pin_fault_control.sv]
// The implementer's own choices: the address map and the Wishbone register port.
`timescale 1ns/100ps
module pwm_timebase_pin_fault_control (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// configuration strap and pins
	input wire logic write_lock_config_bit_i,
	input wire logic external_sync_input_i,
	input wire pwm_ctrl_pkg::fault_in_t fault_pins_i,
	// generator side
	input wire pwm_ctrl_pkg::gen_in_t gen_i,
	output logic tick_o,
	output logic sync_o,
	output logic trigger_o,
	// power stage pins
	output logic high_side_output_o,
	output logic low_side_output_o,
	output logic high_side_oe_o,
	output logic low_side_oe_o
);
	import pwm_ctrl_pkg::*;

	//////////////////////////////////////////////////////////////////////
	// registers and state
	logic [15:0] timebase_ff; // enable, sync source, postscale
	logic [2:0] clkdiv_ff; // input prescale code
	logic [15:0] pinctl_ff; // ownership, polarity, override data
	logic [15:0] faultctl_ff; // source, polarity, mode
	logic lock_ff; // strap level, followed every cycle after reset
	logic key1_ff; // first key seen
	logic unlocked_ff; // one locked write allowed
	logic [3:0] post_cnt_ff; // compare match count
	logic trigger_ff; // trigger pulse
	logic fault_latch_ff; // latched fault condition
	logic fault_cyc_ff; // cycle fault held to cycle end
	logic ack_ff; // bus answer
	logic [31:0] dat_ff; // read data
	logic [1:0] sync_meta_ff; // external sync synchroniser
	logic sync_prev_ff; // sync edge detect
	logic [1:0] strap_sync_ff; // lock strap synchroniser
	logic [13:0] flt_meta_ff; // fault pin synchroniser stage one
	logic [13:0] flt_sync_ff; // fault pin synchroniser stage two
	logic [13:0] flt_raw; // flattened fault pins
	logic fault_sel; // selected raw fault
	logic fault_act; // polarity corrected fault
	logic fault_on; // fault currently driving the pins
	logic bus_req; // new request this cycle
	logic wr_req; // write request
	logic lock_ok; // locked registers writable now
	logic en; // module enable
	logic [15:0] wd; // low half write data
	logic h_gen, l_gen, h_lvl, l_lvl; // pair mode and priority levels

	assign en = timebase_ff[TB_EN_BIT];
	assign wd = dat_i[15:0];
	assign bus_req = cyc_i && stb_i && !ack_ff;
	assign wr_req = bus_req && we_i && sel_i[0] && sel_i[1];
	assign lock_ok = !lock_ff || unlocked_ff;

	//////////////////////////////////////////////////////////////////////
	// two-flop synchronisers for pins and strap
	assign flt_raw = {fault_pins_i.fault32, fault_pins_i.cmp, fault_pins_i.fault};
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_meta_ff <= 2'h0;
			strap_sync_ff <= 2'h3; // resets locked, so no open window after reset
			flt_meta_ff <= 14'h0000;
			flt_sync_ff <= 14'h0000;
		end else begin
			sync_meta_ff <= {sync_meta_ff[0], external_sync_input_i};
			strap_sync_ff <= {strap_sync_ff[0], write_lock_config_bit_i};
			flt_meta_ff <= flt_raw;
			flt_sync_ff <= flt_meta_ff;
		end
	end

	// lock level is taken from the synchronised strap after release
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lock_ff <= 1'b1;
		end else begin
			lock_ff <= strap_sync_ff[1];
		end
	end

	//////////////////////////////////////////////////////////////////////
	// bus answer: one wait state, ack for a single cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= bus_req;
		end
	end
	assign ack_o = ack_ff;

	// read mux; unmapped addresses read zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_ff <= 32'h0000_0000;
		end else if (bus_req && !we_i) begin
			case (adr_i)
				OFS_TIMEBASE: dat_ff <= {16'h0000, timebase_ff};
				OFS_CLKDIV: dat_ff <= {29'h0, clkdiv_ff};
				OFS_PINCTL: dat_ff <= {16'h0000, pinctl_ff};
				OFS_FAULTCTL: dat_ff <= {16'h0000, faultctl_ff};
				OFS_STATUS: dat_ff <= {28'h0, fault_on, unlocked_ff, lock_ff, fault_latch_ff};
				default: dat_ff <= 32'h0000_0000;
			endcase
		end
	end
	assign dat_o = dat_ff;

	//////////////////////////////////////////////////////////////////////
	// unlock key sequence: key1 then key2 opens one locked write
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			key1_ff <= 1'b0;
			unlocked_ff <= 1'b0;
		end else if (wr_req) begin
			if (adr_i == OFS_UNLOCK) begin
				key1_ff <= (wd == UNLOCK_KEY1);
				unlocked_ff <= key1_ff && (wd == UNLOCK_KEY2);
			end else if (adr_i == OFS_PINCTL || adr_i == OFS_FAULTCTL) begin
				key1_ff <= 1'b0;
				unlocked_ff <= 1'b0;
			end
		end
	end

	// plain registers; prescale and sync codes are stored as written
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timebase_ff <= TIMEBASE_RST;
			clkdiv_ff <= CLKDIV_RST;
		end else if (wr_req) begin
			if (adr_i == OFS_TIMEBASE) begin
				timebase_ff <= wd & 16'h807F;
			end
			if (adr_i == OFS_CLKDIV) begin
				clkdiv_ff <= wd[2:0];
			end
		end
	end

	// locked registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pinctl_ff <= PINCTL_RST;
			faultctl_ff <= FAULTCTL_RST;
		end else if (wr_req && lock_ok) begin
			if (adr_i == OFS_PINCTL) begin
				pinctl_ff <= wd & 16'hFFFC;
			end
			if (adr_i == OFS_FAULTCTL) begin
				faultctl_ff <= wd & 16'h80FF;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// prescaler
	pwm_clk_prescaler u_prescale (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(en),
		.sel_i(clkdiv_ff),
		.tick_o(tick_o)
	);

	// external sync only on code zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_prev_ff <= 1'b0;
		end else begin
			sync_prev_ff <= sync_meta_ff[1];
		end
	end
	assign sync_o = en && (timebase_ff[6:4] == SYNC_EXT) && sync_meta_ff[1] && !sync_prev_ff;

	always_ff @(posedge clk_i) begin
		if (rst_i || !en) begin
			post_cnt_ff <= 4'h0;
			trigger_ff <= 1'b0;
		end else if (gen_i.cmp_match) begin
			if (post_cnt_ff >= timebase_ff[3:0]) begin
				post_cnt_ff <= 4'h0;
				trigger_ff <= 1'b1;
			end else begin
				post_cnt_ff <= post_cnt_ff + 4'h1;
				trigger_ff <= 1'b0;
			end
		end else begin
			trigger_ff <= 1'b0;
		end
	end
	assign trigger_o = trigger_ff;

	//////////////////////////////////////////////////////////////////////
	// fault source select, reserved codes select a low input, so they fault only with inverted polarity
	always_comb begin
		if (faultctl_ff[7:3] <= FSRC_LAST_CMP) begin
			fault_sel = flt_sync_ff[faultctl_ff[6:3]];
		end else if (faultctl_ff[7:3] == FSRC_FAULT32) begin
			fault_sel = flt_sync_ff[13];
		end else begin
			fault_sel = 1'b0;
		end
	end

	assign fault_act = fault_sel ^ faultctl_ff[FC_POL_BIT];

	// latched fault clears only on a write of the fault register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_latch_ff <= 1'b0;
		end else if (faultctl_ff[1:0] == FMOD_LATCH && fault_act) begin
			fault_latch_ff <= 1'b1;
		end else if ((wr_req && lock_ok && adr_i == OFS_FAULTCTL)
			|| faultctl_ff[1:0] != FMOD_LATCH) begin
			fault_latch_ff <= 1'b0;
		end
	end

	// cycle fault held until the next cycle start
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fault_cyc_ff <= 1'b0;
		end else if (faultctl_ff[1:0] == FMOD_CYCLE && fault_act) begin
			fault_cyc_ff <= 1'b1;
		end else if (gen_i.cycle_start || faultctl_ff[1:0] != FMOD_CYCLE) begin
			fault_cyc_ff <= 1'b0;
		end
	end

	assign fault_on = fault_latch_ff
		|| (faultctl_ff[1:0] == FMOD_CYCLE && (fault_cyc_ff || fault_act));

	//////////////////////////////////////////////////////////////////////
	// pin-pair mode
	always_comb begin
		case (pinctl_ff[PC_MODE_LSB +: 2])
			PAIR_COMPL: begin
				h_gen = gen_i.wave_h;
				l_gen = !gen_i.wave_h;
			end
			PAIR_REDUND: begin
				h_gen = gen_i.wave_h;
				l_gen = gen_i.wave_h;
			end
			PAIR_PUSHPULL: begin
				h_gen = gen_i.wave_h;
				l_gen = gen_i.wave_l;
			end
			default: begin
				h_gen = 1'b0;
				l_gen = 1'b0;
			end
		endcase
	end

	always_comb begin
		if (fault_on) begin
			h_lvl = pinctl_ff[PC_FAULT_DATA_LSB + 1];
			l_lvl = pinctl_ff[PC_FAULT_DATA_LSB];
		end else if (gen_i.limit_active && faultctl_ff[FC_CLACT_BIT]) begin
			h_lvl = pinctl_ff[PC_LIMIT_DATA_LSB + 1];
			l_lvl = pinctl_ff[PC_LIMIT_DATA_LSB];
		end else begin
			h_lvl = pinctl_ff[PC_OVRH_BIT] ? pinctl_ff[PC_OVR_DATA_LSB + 1] : (en && h_gen);
			l_lvl = pinctl_ff[PC_OVRL_BIT] ? pinctl_ff[PC_OVR_DATA_LSB] : (en && l_gen);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			high_side_output_o <= 1'b0;
			low_side_output_o <= 1'b0;
			high_side_oe_o <= 1'b0;
			low_side_oe_o <= 1'b0;
		end else begin
			high_side_output_o <= h_lvl ^ pinctl_ff[PC_POL_H_BIT];
			low_side_output_o <= l_lvl ^ pinctl_ff[PC_POLL_BIT];
			high_side_oe_o <= pinctl_ff[PC_OWN_H_BIT];
			low_side_oe_o <= pinctl_ff[PC_OWN_L_BIT];
		end
	end
	//////////////////////////////////////////////////////////////////////
	// checks
	property p_ack_one;
		@(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
	property p_lock_block;
		@(posedge clk_i) disable iff (rst_i)
		(wr_req && adr_i == OFS_PINCTL && lock_ff && !unlocked_ff) |=> $stable(pinctl_ff);
	endproperty
	a_lock_block: assert property (p_lock_block) else $error("locked pin write");
	property p_lock_fault;
		@(posedge clk_i) disable iff (rst_i)
		(wr_req && adr_i == OFS_FAULTCTL && lock_ff && !unlocked_ff) |=> $stable(faultctl_ff);
	endproperty
	a_lock_fault: assert property (p_lock_fault) else $error("locked fault write");
	property p_sync_src;
		@(posedge clk_i) disable iff (rst_i) (timebase_ff[6:4] != SYNC_EXT) |-> !sync_o;
	endproperty
	a_sync_src: assert property (p_sync_src) else $error("reserved sync source");
	property p_post_one;
		@(posedge clk_i) disable iff (rst_i)
		(en && timebase_ff[3:0] == 4'h0 && gen_i.cmp_match) |=> trigger_o;
	endproperty
	a_post_one: assert property (p_post_one) else $error("1:1 trigger missing");
	// pin level is launched from the settings of the cycle before, so compare against those
	property p_fault_drive;
		@(posedge clk_i) disable iff (rst_i)
		fault_on |=> high_side_output_o
			== ($past(pinctl_ff[PC_FAULT_DATA_LSB + 1]) ^ $past(pinctl_ff[PC_POL_H_BIT]));
	endproperty
	a_fault_drive: assert property (p_fault_drive) else $error("fault data not driven");
	property p_latch_hold;
		@(posedge clk_i) disable iff (rst_i)
		(fault_latch_ff && faultctl_ff[1:0] == FMOD_LATCH && !wr_req) |=> fault_latch_ff;
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latched fault dropped");
	property p_fault_off;
		@(posedge clk_i) disable iff (rst_i) (faultctl_ff[1:0] == 2'h3) |=> !fault_cyc_ff;
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("disabled fault active");
	property p_reserved_src;
		@(posedge clk_i) disable iff (rst_i)
		(faultctl_ff[7:3] > FSRC_LAST_CMP && faultctl_ff[7:3] != FSRC_FAULT32) |-> !fault_sel;
	endproperty
	a_reserved_src: assert property (p_reserved_src) else $error("reserved source faults");
	property p_oe_own;
		@(posedge clk_i) disable iff (rst_i) 1'b1 |=> high_side_oe_o == $past(pinctl_ff[15]);
	endproperty
	a_oe_own: assert property (p_oe_own) else $error("ownership not applied");
endmodule : pwm_timebase_pin_fault_control

// [hw/pwm_ctrl_pkg.sv]
package pwm_ctrl_pkg;

	// register word offsets (byte addresses)
	localparam logic [7:0] OFS_TIMEBASE = 8'h00;
	localparam logic [7:0] OFS_CLKDIV = 8'h04;
	localparam logic [7:0] OFS_PINCTL = 8'h08;
	localparam logic [7:0] OFS_FAULTCTL = 8'h0C;
	localparam logic [7:0] OFS_UNLOCK = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;

	// unlock key pair, written in this order to the unlock register
	localparam logic [15:0] UNLOCK_KEY1 = 16'hABCD;
	localparam logic [15:0] UNLOCK_KEY2 = 16'h4321;

	// timebase control field positions
	localparam int TB_EN_BIT = 15;
	localparam int TB_SRC_LSB = 4;
	localparam int TB_POST_LSB = 0;

	// pin control field positions
	localparam int PC_OWN_H_BIT = 15;
	localparam int PC_OWN_L_BIT = 14;
	localparam int PC_POL_H_BIT = 13;
	localparam int PC_POLL_BIT = 12;
	localparam int PC_MODE_LSB = 10;
	localparam int PC_OVRH_BIT = 9;
	localparam int PC_OVRL_BIT = 8;
	localparam int PC_OVR_DATA_LSB = 6;
	localparam int PC_FAULT_DATA_LSB = 4;
	localparam int PC_LIMIT_DATA_LSB = 2;

	// fault control field positions
	localparam int FC_CLACT_BIT = 15;
	localparam int FC_SRC_LSB = 3;
	localparam int FC_POL_BIT = 2;
	localparam int FC_MOD_LSB = 0;

	// reset values
	localparam logic [15:0] TIMEBASE_RST = 16'h0000;
	localparam logic [2:0] CLKDIV_RST = 3'h0;
	localparam logic [15:0] PINCTL_RST = 16'hC000;
	localparam logic [15:0] FAULTCTL_RST = 16'h00F8;

	// encodings
	localparam logic [2:0] SYNC_EXT = 3'h0;
	localparam logic [2:0] CLKDIV_MAX = 3'h6;
	localparam logic [1:0] PAIR_COMPL = 2'h0;
	localparam logic [1:0] PAIR_REDUND = 2'h1;
	localparam logic [1:0] PAIR_PUSHPULL = 2'h2;
	localparam logic [1:0] FMOD_LATCH = 2'h0;
	localparam logic [1:0] FMOD_CYCLE = 2'h1;
	localparam logic [4:0] FSRC_LAST_FAULT = 5'h07;
	localparam logic [4:0] FSRC_LAST_CMP = 5'h0C;
	localparam logic [4:0] FSRC_FAULT32 = 5'h1F;

	// fault and comparator input bundle
	typedef struct packed {
		logic fault32;
		logic [4:0] cmp;
		logic [7:0] fault;
	} fault_in_t;

	// generator waveform and events
	typedef struct packed {
		logic wave_h;
		logic wave_l;
		logic cycle_start;
		logic cmp_match;
		logic limit_active;
	} gen_in_t;

endpackage : pwm_ctrl_pkg

// [hw/pwm_clk_prescaler.sv]
`timescale 1ns/100ps
module pwm_clk_prescaler (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control
	input wire logic run_i,
	input wire logic [2:0] sel_i,
	// divided enable
	output logic tick_o
);
	import pwm_ctrl_pkg::*;

	logic [5:0] cnt_ff; // free count, cleared while stopped
	logic [5:0] mask; // low bits that must be all ones

	// mask of 2^sel - 1; reserved code gives no tick
	always_comb begin
		mask = 6'(({6'h0, 1'b1} << sel_i) - 7'h01);
	end

	//////////////////////////////////////////////////////////////////////
	// counter restarts when the time base stops so ticks stay aligned
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			cnt_ff <= 6'h00;
		end else begin
			cnt_ff <= cnt_ff + 6'h01;
		end
	end

	assign tick_o = run_i && (sel_i <= CLKDIV_MAX) && ((cnt_ff & mask) == mask);

endmodule : pwm_clk_prescaler

// [bench/pwm_stage_model.sv]
`timescale 1ns/100ps
////////////////////////////////////////
// gate driver of the power stage: a pin the module has released
// is pulled low by the driver, so a stale level never shows
module pwm_stage_model (
	// module side pins
	input wire logic out_h_i,
	input wire logic out_l_i,
	input wire logic oe_h_i,
	input wire logic oe_l_i,
	// levels seen at the gates
	output logic gate_h_o,
	output logic gate_l_o
);
	assign gate_h_o = oe_h_i ? out_h_i : 1'b0;
	assign gate_l_o = oe_l_i ? out_l_i : 1'b0;
endmodule : pwm_stage_model

// [bench/tb_pwm_timebase_pin_fault_control.sv]
`timescale 1ns/100ps
module tb_pwm_timebase_pin_fault_control;
	import pwm_ctrl_pkg::*;
	// bus and strap stimulus
	logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, lock_i = 1, xsync = 0;
	logic [7:0] adr_i = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat_i = 32'h0, dat_o;
	logic ack_o, tick_o, sync_o, trig_o, hs, ls, hoe, loe, ph, pl, pol;
	fault_in_t flt = '0;
	gen_in_t gen = '0;
	// tallies and shadow state of the model
	int err_total = 0, num_checks = 0, cyc_cnt = 0, tk, sy, tg, n, idx;
	logic [31:0] rnd = 32'hBB40;
	logic [15:0] q, pc;
	logic [13:0] f;
	logic [4:0] code;
	logic [7:0] ra [5] = '{OFS_TIMEBASE, OFS_CLKDIV, OFS_PINCTL, OFS_FAULTCTL, 8'h3C};
	logic [15:0] rv [5] = '{TIMEBASE_RST, {13'h0, CLKDIV_RST}, PINCTL_RST, FAULTCTL_RST, 16'h0};

	always #20 clk_i = ~clk_i;

	pwm_timebase_pin_fault_control DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .write_lock_config_bit_i(lock_i),
		.external_sync_input_i(xsync), .fault_pins_i(flt), .gen_i(gen), .tick_o(tick_o),
		.sync_o(sync_o), .trigger_o(trig_o), .high_side_output_o(hs), .low_side_output_o(ls),
		.high_side_oe_o(hoe), .low_side_oe_o(loe));

	pwm_stage_model stage (.out_h_i(hs), .out_l_i(ls), .oe_h_i(hoe), .oe_l_i(loe),
		.gate_h_o(ph), .gate_l_o(pl));

	////////////////////////////////////////
	// pseudo-random source, fixed start
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr

	// expected gate pair: fault over limit over override over waveform
	function automatic logic [1:0] pins(input logic [15:0] p, input logic fa, input logic lim);
		logic [1:0] w;
		logic [1:0] v;
		// pair mode: complementary, redundant, push-pull, reserved low
		case (p[PC_MODE_LSB +: 2])
			2'h0: w = {gen.wave_h, ~gen.wave_h};
			2'h1: w = {gen.wave_h, gen.wave_h};
			2'h2: w = {gen.wave_h, gen.wave_l};
			default: w = 2'h0;
		endcase
		v[1] = p[PC_OVRH_BIT] ? p[PC_OVR_DATA_LSB + 1] : w[1];
		v[0] = p[PC_OVRL_BIT] ? p[PC_OVR_DATA_LSB] : w[0];
		if (lim) begin
			v = p[PC_LIMIT_DATA_LSB +: 2];
		end
		if (fa) begin
			v = p[PC_FAULT_DATA_LSB +: 2];
		end
		// polarity flips, then released pins read low
		v = v ^ p[PC_POLL_BIT +: 2];
		return v & p[PC_OWN_L_BIT +: 2];
	endfunction : pins

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		num_checks++;
		if (s !== e) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk

	// one classic cycle; waits for ack however long it takes
	task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		sel <= 4'hF;
		adr_i <= a;
		dat_i <= {16'h0000, d};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o[15:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		sel <= 4'h0;
		@(posedge clk_i);
	endtask : bus

	// key pair before a guarded write
	task automatic wl(input logic [7:0] a, input logic [15:0] d);
		bus(1'b1, OFS_UNLOCK, UNLOCK_KEY1);
		bus(1'b1, OFS_UNLOCK, UNLOCK_KEY2);
		bus(1'b1, a, d);
	endtask : wl

	// clock c cycles, tallying pulses; m toggles compare matches
	task automatic run(input int c, input logic m);
		repeat (c) begin
			@(posedge clk_i);
			tk += (tick_o === 1'b1);
			sy += (sync_o === 1'b1);
			tg += (trig_o === 1'b1);
			gen.cmp_match <= m & ~gen.cmp_match;
		end
	endtask : run

	task automatic pin(input logic fa, input logic lim);
		run(6, 1'b0);
		chk({14'h0, ph, pl}, {14'h0, pins(pc, fa, lim)});
	endtask : pin

	// config writes happen with the time base stopped, except the latch-clearing fault write at the end
	// change while stopped
	task automatic cfg(input logic [7:0] a, input logic [15:0] d, input logic g);
		bus(1'b1, OFS_TIMEBASE, 16'h0000);
		if (g) begin
			wl(a, d);
		end else begin
			bus(1'b1, a, d);
		end
	endtask : cfg

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report

	// a hang counts as a mismatch
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 20000) begin
			err_total++;
			final_report();
		end
	end

	////////////////////////////////////////
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		// reset values and an unmapped hole
		foreach (ra[i]) begin
			bus(1'b0, ra[i], 16'h0000);
			chk(q, rv[i]);
		end
		// guarded writes without keys are dropped
		bus(1'b1, OFS_PINCTL, 16'h3300);
		bus(1'b1, OFS_FAULTCTL, 16'h0003);
		bus(1'b0, OFS_PINCTL, 16'h0000);
		chk(q, PINCTL_RST);
		bus(1'b0, OFS_FAULTCTL, 16'h0000);
		chk(q, FAULTCTL_RST);
		// keys open exactly one write
		wl(OFS_PINCTL, 16'h3300);
		bus(1'b1, OFS_PINCTL, 16'hC000);
		bus(1'b0, OFS_PINCTL, 16'h0000);
		chk(q, 16'h3300);
		wl(OFS_FAULTCTL, 16'h0003);
		bus(1'b0, OFS_FAULTCTL, 16'h0000);
		chk(q, 16'h0003);
		// every prescale code, 128-cycle window
		for (int c = 0; c < 8; c++) begin
			cfg(OFS_CLKDIV, 16'(c), 1'b0);
			bus(1'b1, OFS_TIMEBASE, 16'h8000);
			tk = 0;
			run(128, 1'b0);
			chk(16'(tk), (c == 7) ? 16'h0 : 16'(128 >> c));
		end
		// postscaler: 2(N+1) matches give two triggers
		for (int i = 0; i < 4; i++) begin
			n = (i == 0) ? 0 : (i == 3) ? 15 : int'(rnd[3:0]);
			rnd = lfsr(rnd);
			cfg(OFS_TIMEBASE, 16'(n), 1'b0);
			bus(1'b1, OFS_TIMEBASE, 16'(n) | 16'h8000);
			tg = 0;
			run(4 * (n + 1), 1'b1);
			run(4, 1'b0);
			chk(16'(tg), 16'h0002);
		end
		// sync edge passes only for source 000
		for (int s = 0; s < 8; s++) begin
			cfg(OFS_TIMEBASE, 16'(s << TB_SRC_LSB), 1'b0);
			bus(1'b1, OFS_TIMEBASE, 16'(s << TB_SRC_LSB) | 16'h8000);
			sy = 0;
			xsync <= 1'b1;
			run(8, 1'b0);
			xsync <= 1'b0;
			run(8, 1'b0);
			chk(16'(sy), (s == 0) ? 16'h1 : 16'h0);
		end
		// random pin setups, fault 0 present, limit and mode drawn
		flt <= 14'h0001;
		for (int i = 0; i < 12; i++) begin
			pc = rnd[15:0] & 16'hFFFC;
			rnd = lfsr(rnd);
			cfg(OFS_PINCTL, pc, 1'b1);
			wl(OFS_FAULTCTL, {rnd[0], 12'h000, 1'b0, rnd[1] ? FMOD_CYCLE : 2'h3});
			gen.wave_h <= rnd[2];
			gen.wave_l <= rnd[4];
			gen.limit_active <= rnd[3];
			bus(1'b1, OFS_TIMEBASE, 16'h8000);
			pin(rnd[1], rnd[0] & rnd[3]);
			chk({14'h0, hoe, loe}, {14'h0, pc[15:14]});
		end
		// every fault source, random polarity, cycle mode
		pc = 16'hC030;
		cfg(OFS_PINCTL, pc, 1'b1);
		for (int k = 0; k < 16; k++) begin
			code = (k < 13) ? 5'(k) : (k == 13) ? FSRC_FAULT32 : 5'(k + 3);
			idx = (k < 14) ? k : -1;
			f = rnd[13:0];
			rnd = lfsr(rnd);
			pol = rnd[0];
			if (idx >= 0) begin
				f[idx] = pol;
			end
			flt <= f;
			cfg(OFS_FAULTCTL, {8'h00, code, pol, FMOD_CYCLE}, 1'b1);
			bus(1'b1, OFS_TIMEBASE, 16'h8000);
			// a cycle fault caught under the old setup is held until a cycle start
			gen.cycle_start <= 1'b1;
			run(1, 1'b0);
			gen.cycle_start <= 1'b0;
			pin(1'b0, 1'b0);
			if (idx >= 0) begin
				f[idx] = ~pol;
			end else begin
				f = ~f;
			end
			flt <= f;
			pin(idx >= 0, 1'b0);
			if (idx >= 0) begin
				f[idx] = pol;
			end
			flt <= f;
			pin(idx >= 0, 1'b0);
			gen.cycle_start <= 1'b1;
			run(1, 1'b0);
			gen.cycle_start <= 1'b0;
			pin(1'b0, 1'b0);
		end
		// latched fault outlives the cycle start until a write
		flt <= 14'h0000;
		cfg(OFS_FAULTCTL, 16'h0000, 1'b1);
		bus(1'b1, OFS_TIMEBASE, 16'h8000);
		flt <= 14'h0001;
		pin(1'b1, 1'b0);
		flt <= 14'h0000;
		gen.cycle_start <= 1'b1;
		run(1, 1'b0);
		gen.cycle_start <= 1'b0;
		pin(1'b1, 1'b0);
		wl(OFS_FAULTCTL, 16'h0000);
		pin(1'b0, 1'b0);
		final_report();
	end
endmodule : tb_pwm_timebase_pin_fault_control
